// ---- pkg/mbcg_pkg.sv ----
// constants for base clock division and the mains-locked chip clock
package mbcg_pkg;
    // base clock rate of this implementation
    localparam int CLK_HZ = 40_000_000;
    // transmitter and receiver division ratios
    localparam int TX_DIV = 4;
    localparam int RX_DIV = 8;
    // receiver tick rate, which paces the mains-locked loop
    localparam int RX_TICK_HZ = CLK_HZ / RX_DIV;
    // mains frequencies and the limits the loop accepts
    localparam int MAINS_NOM_HZ = 50;
    localparam int MAINS_MAX_HZ = 70;
    localparam int MAINS_MIN_HZ = 40;
    // mains period in receiver ticks
    localparam int PERIOD_NOM = RX_TICK_HZ / MAINS_NOM_HZ;
    localparam int PERIOD_MIN = RX_TICK_HZ / MAINS_MAX_HZ;
    localparam int PERIOD_MAX = RX_TICK_HZ / MAINS_MIN_HZ;
    localparam int PERIOD_W = 18;
    // chip clock runs 8 times the bit rate
    localparam int CHIPS_PER_BIT = 8;
    localparam int CHIP_IDX_W = 3;
    // 3 bits per half cycle at the slowest setting, so 6 per period
    localparam int BASE_BITS_PER_PERIOD = 6;
    localparam logic [8:0] BASE_CHIPS = 9'(BASE_BITS_PER_PERIOD * CHIPS_PER_BIT);
    localparam int RATE_SEL_W = 2;
endpackage

// ---- logic/mbcg_div.sv ----
// divider that turns the base clock into a one-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
module mbcg_div #(
    parameter int DIVISOR = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    output logic tick
);
    localparam int CW = $clog2(DIVISOR);
    localparam logic [CW-1:0] LAST = CW'(DIVISOR - 1);

    logic [CW-1:0] cnt_q;

    // counter clears on reset so the phase of every divided clock is known
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // registered pulse, high one cycle in DIVISOR
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == LAST);
        end
    end
endmodule
`default_nettype wire

// ---- logic/mbcg_clock_gen.sv ----
// base clock generation: source strap, core/tx/rx enables and mains-locked chip clock
//
// Behaviour
// - high strap selects external clock on input
// - core runs from undivided base clock
// - transmitter clock is base divided by four
// - receiver clock is base divided by eight
// - tx/rx timing derived from their divided clocks
// - transmission synchronised by mains-locked loop
// - supports 3,6,12,24 bits per half cycle
// - chip clock runs eight times bit rate
`timescale 1ns/10ps
`default_nettype none
module mbcg_clock_gen #(
    parameter int PERIOD_NOM = mbcg_pkg::PERIOD_NOM,
    parameter int PERIOD_MIN = mbcg_pkg::PERIOD_MIN,
    parameter int PERIOD_MAX = mbcg_pkg::PERIOD_MAX
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clock_source_select_strap,
    input wire logic zeroCrossIn,
    input wire logic [mbcg_pkg::RATE_SEL_W-1:0] bitRateSel,
    output logic extClkMode_q,
    output logic oscDriveEn_q,
    output logic coreClkEn_q,
    output logic txClkEn,
    output logic rxClkEn,
    output logic chipClkEn_q,
    output logic bitStrobe_q,
    output logic txChipEn_q,
    output logic pllLocked_q
);
    localparam int PW = mbcg_pkg::PERIOD_W;
    localparam logic [PW-1:0] P_NOM = PW'(PERIOD_NOM);
    localparam logic [PW-1:0] P_MIN = PW'(PERIOD_MIN);
    localparam logic [PW-1:0] P_MAX = PW'(PERIOD_MAX);

    logic strapDone_q;
    logic zcPrev_q;
    logic [PW-1:0] periodCnt_q;
    logic [PW-1:0] period_q;
    logic [PW-1:0] acc_q;
    logic [mbcg_pkg::CHIP_IDX_W-1:0] chipIdx_q;
    logic txPending_q;
    logic zcRise;
    logic [8:0] chipsPerPeriod;
    logic [PW:0] accSum;
    logic chipEvt;

    // dividers are plain enables in the base domain, no derived clocks
    mbcg_div #(.DIVISOR(mbcg_pkg::TX_DIV)) uTxDiv (
        .mclk(mclk),
        .resetn(resetn),
        .tick(txClkEn)
    );
    mbcg_div #(.DIVISOR(mbcg_pkg::RX_DIV)) uRxDiv (
        .mclk(mclk),
        .resetn(resetn),
        .tick(rxClkEn)
    );

    // strap is caught once after reset release, not under the reset itself
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strapDone_q <= 1'b0;
            extClkMode_q <= 1'b0;
            oscDriveEn_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapDone_q <= 1'b1;
            extClkMode_q <= clock_source_select_strap;
            // inverter stage only drives a crystal; in external mode it stays off
            oscDriveEn_q <= !clock_source_select_strap;
        end
    end

    // core enable is low in reset and high from the first edge after release: the core then sees every base edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            coreClkEn_q <= 1'b0;
        end else begin
            coreClkEn_q <= 1'b1;
        end
    end

    // zero crossing is sampled on receiver ticks; pulses under 8 cycles can be missed
    assign zcRise = rxClkEn && zeroCrossIn && !zcPrev_q;
    assign chipsPerPeriod = mbcg_pkg::BASE_CHIPS << bitRateSel;
    assign accSum = {1'b0, acc_q} + (PW+1)'(chipsPerPeriod);
    assign chipEvt = rxClkEn && (zcRise || (accSum >= {1'b0, period_q}));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            zcPrev_q <= 1'b0;
        end else if (rxClkEn) begin
            zcPrev_q <= zeroCrossIn;
        end
    end

    // mains period measured in receiver ticks, saturating when edges stop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            periodCnt_q <= '0;
        end else if (rxClkEn) begin
            if (zcRise) begin
                periodCnt_q <= PW'(1);
            end else if (periodCnt_q < P_MAX) begin
                periodCnt_q <= periodCnt_q + 1'b1;
            end
        end
    end

    // only plausible periods are taken; without edges the last one is kept (flywheel)
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            period_q <= P_NOM;
            pllLocked_q <= 1'b0;
        end else if (rxClkEn) begin
            if (zcRise && periodCnt_q >= P_MIN && periodCnt_q < P_MAX) begin
                period_q <= periodCnt_q;
                pllLocked_q <= 1'b1;
            end else if (periodCnt_q == P_MAX) begin
                pllLocked_q <= 1'b0;
            end
        end
    end

    // fractional accumulator: chipsPerPeriod chip events per measured period
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= '0;
        end else if (rxClkEn) begin
            if (zcRise) begin
                acc_q <= '0;
            end else if (accSum >= {1'b0, period_q}) begin
                acc_q <= PW'(accSum - {1'b0, period_q});
            end else begin
                acc_q <= accSum[PW-1:0];
            end
        end
    end

    // chip index within a bit; the rising mains edge restarts bit alignment
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            chipIdx_q <= '0;
            chipClkEn_q <= 1'b0;
            bitStrobe_q <= 1'b0;
        end else begin
            chipClkEn_q <= chipEvt;
            bitStrobe_q <= chipEvt && (zcRise || chipIdx_q == '1);
            if (chipEvt) begin
                chipIdx_q <= zcRise ? '0 : chipIdx_q + 1'b1;
            end
        end
    end

    // chip event handed to the tx side on its own tick; a new event wins over the clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txPending_q <= 1'b0;
            txChipEn_q <= 1'b0;
        end else begin
            txPending_q <= chipClkEn_q || (txPending_q && !txClkEn);
            txChipEn_q <= txClkEn && txPending_q;
        end
    end

    a_core_every_edge: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) |-> coreClkEn_q)
        else $error("core enable dropped");

    a_tx_div_four: assert property (@(posedge mclk) disable iff (!resetn)
        txClkEn |=> !txClkEn [*3] ##1 txClkEn)
        else $error("tx enable not one in four");

    a_rx_div_eight: assert property (@(posedge mclk) disable iff (!resetn)
        rxClkEn |=> !rxClkEn [*7] ##1 rxClkEn)
        else $error("rx enable not one in eight");

    a_chip_on_rx: assert property (@(posedge mclk) disable iff (!resetn)
        chipClkEn_q |-> $past(rxClkEn))
        else $error("chip event off the rx tick");

    a_tx_chip_follows: assert property (@(posedge mclk) disable iff (!resetn)
        chipClkEn_q |-> ##[1:5] txChipEn_q)
        else $error("chip event not passed to tx side");

    a_pll_phase_lock: assert property (@(posedge mclk) disable iff (!resetn)
        zcRise |=> chipClkEn_q && bitStrobe_q && chipIdx_q == '0 && acc_q == '0)
        else $error("mains edge did not realign chip clock");

    a_rate_chips: assert property (@(posedge mclk) disable iff (!resetn)
        chipsPerPeriod == (9'h30 << bitRateSel))
        else $error("chips per period wrong for rate");

    a_bit_per_eight: assert property (@(posedge mclk) disable iff (!resetn)
        bitStrobe_q && !$past(zcRise) |-> chipClkEn_q && chipIdx_q == '0)
        else $error("bit strobe not every eighth chip");

    a_strap_ext: assert property (@(posedge mclk) disable iff (!resetn)
        strapDone_q && extClkMode_q |-> !oscDriveEn_q)
        else $error("oscillator driven in external mode");

    c_external_mode: cover property (@(posedge mclk) disable iff (!resetn) extClkMode_q);
    c_locked: cover property (@(posedge mclk) disable iff (!resetn) $rose(pllLocked_q));
    c_tx_chip: cover property (@(posedge mclk) disable iff (!resetn) txChipEn_q && pllLocked_q);
    c_fast_rate: cover property (@(posedge mclk) disable iff (!resetn) bitStrobe_q && bitRateSel == 2'h3);
endmodule
`default_nettype wire

// ---- test/mbcg_mains_model.sv ----
// mains zero-crossing source that feeds the clock generator
`timescale 1ns/10ps
`default_nettype none
module mbcg_mains_model #(
    parameter int PERIOD = 3072
) (
    input wire logic mclk,
    input wire logic run,
    output logic zeroCross
);
    int cnt = 0;
    initial zeroCross = 1'b0;
    // high in the first half period; a stopped source holds the line low
    always @(posedge mclk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        zeroCross <= #1 run && (cnt < PERIOD / 2);
    end
endmodule
`default_nettype wire

// ---- test/test_mbcg_clock_gen.sv ----
// self-checking bench for the base clock generator
`timescale 1ns/10ps
`default_nettype none
module test_mbcg_clock_gen;
    localparam int MPER = 3072; // 384 rx ticks, a whole number of chips at every rate
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic strap = 1'b0;
    logic run = 1'b0;
    logic [1:0] rate = 2'h0;
    logic zc, extMode, oscEn, coreEn, txEn, rxEn, chipEn, bitEn, txChip, locked;
    int error_cnt = 0;
    int samples_checked = 0;
    // base clock comes straight from the bench; nothing here is clocked off the oscillator drive
    always #12.5 mclk = ~mclk;
    mbcg_mains_model #(.PERIOD(MPER)) mbcg_mains_model_i (.mclk(mclk), .run(run), .zeroCross(zc));
    mbcg_clock_gen #(.PERIOD_NOM(384), .PERIOD_MIN(200), .PERIOD_MAX(800)) mbcg_clock_gen_i (
        .mclk(mclk), .resetn(resetn), .clock_source_select_strap(strap), .zeroCrossIn(zc),
        .bitRateSel(rate), .extClkMode_q(extMode), .oscDriveEn_q(oscEn), .coreClkEn_q(coreEn),
        .txClkEn(txEn), .rxClkEn(rxEn), .chipClkEn_q(chipEn), .bitStrobe_q(bitEn),
        .txChipEn_q(txChip), .pllLocked_q(locked));
    task automatic check(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic check_n(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("ERROR %0t: %s count %0d", $time, what, got);
        end
    endtask
    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset(input logic s);
        resetn = 1'b0;
        strap = s;
        step(16);
        resetn = 1'b1;
    endtask
    // strap is taken once; a later change must not reach the mode
    task automatic test_strap;
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            step(1);
            strap = ~s[0];
            check(extMode, s[0], "ext mode");
            check(oscEn, ~s[0], "osc drive");
            step(5);
            check(extMode, s[0], "ext mode held");
            check(oscEn, ~s[0], "osc drive held");
        end
    endtask
    // enable phases from release, then an asynchronous reset mid-run
    task automatic test_div;
        do_reset(1'b0);
        for (int k = 1; k <= 24; k++) begin
            step(1);
            check(txEn, k % 4 == 0, "tx enable");
            check(rxEn, k % 8 == 0, "rx enable");
            check(coreEn, 1'b1, "core enable");
        end
        step(1);
        resetn = 1'b0;
        #1;
        check(txEn | rxEn | coreEn, 1'b0, "outputs in reset");
        do_reset(1'b0);
    endtask
    // chip and bit events per mains period at every rate
    task automatic test_rates;
        int nc, nb, d;
        run = 1'b1;
        for (int r = 0; r < 4; r++) begin
            rate = r[1:0];
            step(2 * MPER);
            nc = 0;
            nb = 0;
            for (int k = 0; k < 2 * MPER; k++) begin
                step(1);
                nc += int'(chipEn === 1'b1);
                nb += int'(bitEn === 1'b1);
            end
            check_n(nc, 2 * (48 << r), 2 * (48 << r), "chips");
            check_n(nb, 2 * (6 << r), 2 * (6 << r), "bits");
            check(locked, 1'b1, "lock");
            d = 0;
            while (chipEn !== 1'b1 && d < 4000) begin
                step(1);
                d++;
            end
            d = 0;
            do begin
                step(1);
                d++;
            end while (txChip !== 1'b1 && d < 10);
            check_n(d, 2, 5, "tx chip delay");
        end
    endtask
    // a silent mains line drops the lock
    task automatic test_lockloss;
        run = 1'b0;
        step(800 * 8 + 3200);
        check(locked, 1'b0, "lock after silence");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog: the run needs about 1.5 ms, so 2 ms keeps a hang under 80k cycles
    initial begin
        #2_000_000;
        error_cnt++;
        results();
    end
    initial begin
        test_strap();
        test_div();
        test_rates();
        test_lockloss();
        results();
    end
endmodule
`default_nettype wire
